// ==== rtl/nsov_defs.svh ====
// Purpose: constants of the negative-sequence overvoltage trip block
// Assumes: 125 MHz clock, Avalon-MM word addressing in bytes
// Notes:   offsets are byte addresses of 32-bit words
`ifndef NSOV_DEFS_SVH
`define NSOV_DEFS_SVH
// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define NSOV_OFF_CTRL     8'h00
`define NSOV_OFF_VSET     8'h04
`define NSOV_OFF_DELAY    8'h08
`define NSOV_OFF_STATUS   8'h0C
`define NSOV_OFF_IRQ_STAT 8'h10
`define NSOV_OFF_IRQ_EN   8'h14
`define NSOV_OFF_IRQ_CLR  8'h18
`define NSOV_OFF_COUNT    8'h1C
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define NSOV_CTRL_OPER_BIT   0
`define NSOV_CTRL_SONLY_BIT  1
`define NSOV_ST_START_BIT    0
`define NSOV_ST_TRIP_BIT     1
`define NSOV_ST_GST_BIT      2
`define NSOV_ST_GTR_BIT      3
`define NSOV_ST_BLK_BIT      4
// ----------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------
`define NSOV_VSET_RST     8'h1E
`define NSOV_VSET_MIN     8'h02
`define NSOV_VSET_MAX     8'h28
`define NSOV_DELAY_RST    16'h0064
`define NSOV_DELAY_MIN    16'h0032
`define NSOV_DELAY_MAX    16'hEA60
`define NSOV_CTRL_RST     2'h1
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define NSOV_CLK_HZ       125000000
`define NSOV_MS_PER_S     1000
`define NSOV_CYC_PER_MS   (`NSOV_CLK_HZ / `NSOV_MS_PER_S)
`endif

// ==== rtl/nsov_pkg.sv ====
// Purpose: types of the negative-sequence overvoltage trip block
// Assumes: nothing beyond the defs header
// Notes:   bus signals travel as packed structs
package nsov_pkg;
	// ----------------------------------------------------------------
	// bus carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0]  address;
		logic        read;
		logic        write;
		logic [31:0] writedata;
		logic [3:0]  byteenable;
	} nsov_avm_req_t;

	typedef struct packed {
		logic [31:0] readdata;
		logic        waitrequest;
	} nsov_avm_rsp_t;

	// ----------------------------------------------------------------
	// decision states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		NSOV_IDLE,
		NSOV_TIMING,
		NSOV_TRIPPED
	} nsov_state_t;
endpackage

// ==== rtl/nsov_trip.sv ====
// Purpose: definite-time negative-sequence overvoltage start and trip decision
// Assumes: upstream stage supplies negseq voltage in percent with a sample strobe
// Notes:   registers on Avalon-MM, one wait cycle per access
//          block input is a pin and passes two flops; voltage is same-clock
//          out-of-range settings are clamped into range, never refused
//          one millisecond is CYCLES_PER_MS clock cycles
//
// Decided for this implementation: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/100ps
`include "nsov_defs.svh"

module nsov_trip #(
	parameter int VOLT_W        = 8,                  // width of voltage input, percent
	parameter int CYCLES_PER_MS = `NSOV_CYC_PER_MS    // clock cycles per millisecond
) (
	input  wire logic                  clk_i,        // 125 MHz clock
	input  wire logic                  arst_n_i,     // async reset, active low
	input  wire logic [VOLT_W-1:0]     negseq_volt_i,// negseq voltage, percent of nominal
	input  wire logic                  volt_valid_i, // new voltage sample strobe
	input  wire logic                  block_input_i,// user blocking, from pin
	input  wire nsov_pkg::nsov_avm_req_t avm_req_i,  // avalon request
	output      nsov_pkg::nsov_avm_rsp_t avm_rsp_o,  // avalon answer
	output logic                       general_start_out_o, // general start
	output logic                       general_trip_out_o,  // general trip
	output logic                       irq_o         // level interrupt
);
	import nsov_pkg::*;

	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	if (VOLT_W < 6 || VOLT_W > 16) begin : g_bad_w
		$error("VOLT_W must lie in 6..16");
	end
	if (CYCLES_PER_MS < 1 || CYCLES_PER_MS > 1000000) begin : g_bad_ms
		$error("CYCLES_PER_MS out of range");
	end
	// reset values must lie inside the settable ranges
	if (`NSOV_VSET_RST < `NSOV_VSET_MIN || `NSOV_VSET_RST > `NSOV_VSET_MAX) begin : g_vrst
		$error("start voltage reset value out of range");
	end
	if (`NSOV_DELAY_RST < `NSOV_DELAY_MIN ||
	    `NSOV_DELAY_RST > `NSOV_DELAY_MAX) begin : g_drst
		$error("trip delay reset value out of range");
	end

	localparam int MSC_W = $clog2(CYCLES_PER_MS + 1);

	// clamp a written value into [lo,hi]
	function automatic logic [15:0] clamp16(input logic [15:0] v,
	                                        input logic [15:0] lo,
	                                        input logic [15:0] hi);
		if (v < lo)
			return lo;
		else if (v > hi)
			return hi;
		return v;
	endfunction

	// register select, shared by the write strobes and the read mux
	function automatic logic sel(input logic [7:0] a,
	                             input logic [7:0] off);
		return a == off;
	endfunction

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic blk_meta_reg;
	logic blk_sync_reg;

	// two flops on block input; only the second is read, so a
	// metastable first stage never reaches the decision logic
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			blk_meta_reg <= 1'b0;
			blk_sync_reg <= 1'b0;
		end else begin
			blk_meta_reg <= block_input_i;
			blk_sync_reg <= blk_meta_reg;
		end
	end

	// ----------------------------------------------------------------
	// register file
	// ----------------------------------------------------------------
	logic [1:0]  ctrl_reg;
	logic [7:0]  vset_reg;
	logic [15:0] delay_reg;
	logic [1:0]  irq_stat_reg;
	logic [1:0]  irq_en_reg;
	logic        wait_reg;
	logic [31:0] rdata_reg;
	logic [VOLT_W-1:0] volt_reg;
	nsov_state_t state_reg;
	logic [15:0] ms_cnt_reg;
	logic [MSC_W-1:0] cyc_cnt_reg;
	logic        gst_reg;
	logic        gtr_reg;
	logic        irq_reg;

	// access strobes, taken at the edge where waitrequest is low
	wire         wr_stb    = avm_req_i.write & ~wait_reg;
	wire         wr_lo     = avm_req_i.byteenable[0];
	wire         wr_hi     = avm_req_i.byteenable[1];
	wire [7:0]   adr       = avm_req_i.address;
	wire [31:0]  wd        = avm_req_i.writedata;

	// per-register write enables; unmapped offsets write nothing
	wire         wr_ctrl   = wr_stb & wr_lo & sel(adr, `NSOV_OFF_CTRL);
	wire         wr_vset   = wr_stb & wr_lo & sel(adr, `NSOV_OFF_VSET);
	wire         wr_delay  = wr_stb & (wr_lo | wr_hi) & sel(adr, `NSOV_OFF_DELAY);
	wire         wr_irq_en = wr_stb & wr_lo & sel(adr, `NSOV_OFF_IRQ_EN);
	wire         wr_clr    = wr_stb & wr_lo & sel(adr, `NSOV_OFF_IRQ_CLR);

	wire [15:0]  delay_wd  = {wr_hi ? wd[15:8] : delay_reg[15:8],
	                          wr_lo ? wd[7:0]  : delay_reg[7:0]};
	wire [15:0]  vset_cl   = clamp16({8'h00, wd[7:0]},
	                                 {8'h00, `NSOV_VSET_MIN}, {8'h00, `NSOV_VSET_MAX});
	wire [15:0]  delay_cl  = clamp16(delay_wd, `NSOV_DELAY_MIN, `NSOV_DELAY_MAX);

	// ----------------------------------------------------------------
	// decision core
	// ----------------------------------------------------------------
	// operation bit and synced block input each force the function off
	wire         oper_on   = ctrl_reg[`NSOV_CTRL_OPER_BIT];
	wire         start_only = ctrl_reg[`NSOV_CTRL_SONLY_BIT];
	wire         disabled  = blk_sync_reg | ~oper_on;
	// strict compare: a voltage equal to the setting does not start
	wire         above     = ({{(16-VOLT_W){1'b0}}, volt_reg}
	                          > {8'h00, vset_reg});
	wire         ms_tick   = (cyc_cnt_reg == MSC_W'(CYCLES_PER_MS - 1));
	wire         delay_hit = (ms_cnt_reg >= delay_reg);
	wire         int_start = above & ~disabled;
	wire         int_trip  = (state_reg == NSOV_TRIPPED);
	wire         gst_next  = int_start;
	wire         gtr_next  = int_trip & int_start & ~start_only;
	wire         rise_st   = gst_next & ~gst_reg;
	wire         rise_tr   = gtr_next & ~gtr_reg;

	// status word read by software
	wire [31:0]  status_w  = {27'h0, blk_sync_reg, gtr_reg, gst_reg,
	                          int_trip, int_start};
	wire [31:0]  rd_mux    =
		sel(adr, `NSOV_OFF_CTRL)     ? {30'h0, ctrl_reg} :
		sel(adr, `NSOV_OFF_VSET)     ? {24'h0, vset_reg} :
		sel(adr, `NSOV_OFF_DELAY)    ? {16'h0, delay_reg} :
		sel(adr, `NSOV_OFF_STATUS)   ? status_w :
		sel(adr, `NSOV_OFF_IRQ_STAT) ? {30'h0, irq_stat_reg} :
		sel(adr, `NSOV_OFF_IRQ_EN)   ? {30'h0, irq_en_reg} :
		sel(adr, `NSOV_OFF_COUNT)    ? {16'h0, ms_cnt_reg} :
		                              32'h0;

	// voltage sample hold; the value stands between strobes, so a
	// slow upstream stage may strobe once per evaluation tick
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			volt_reg <= '0;
		else if (volt_valid_i)
			volt_reg <= negseq_volt_i;
	end

	// control word: operation enable and start-only flag
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			ctrl_reg <= `NSOV_CTRL_RST;
		else if (wr_ctrl)
			ctrl_reg <= wd[1:0];
	end

	// start voltage, clamped into its settable range
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			vset_reg <= `NSOV_VSET_RST;
		else if (wr_vset)
			vset_reg <= vset_cl[7:0];
	end

	// trip delay in ms, clamped, written byte by byte
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			delay_reg <= `NSOV_DELAY_RST;
		else if (wr_delay)
			delay_reg <= delay_cl;
	end

	// interrupt enables
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			irq_en_reg <= 2'h0;
		else if (wr_irq_en)
			irq_en_reg <= wd[1:0];
	end

	// ----------------------------------------------------------------
	// bus answer
	// ----------------------------------------------------------------
	// one wait cycle: waitrequest drops for one cycle per request,
	// so every access takes two edges and back to back is allowed
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			wait_reg <= 1'b1;
		else
			wait_reg <= ~((avm_req_i.read | avm_req_i.write) & wait_reg);
	end

	// read data stand only while waitrequest is low, zero otherwise
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			rdata_reg <= 32'h0;
		else
			rdata_reg <= (avm_req_i.read & wait_reg) ? rd_mux : 32'h0;
	end

	// millisecond prescaler, runs only while int_start is high
	// held at zero otherwise, so every start times a full first ms
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			cyc_cnt_reg <= '0;
		else if (!int_start || ms_tick)
			cyc_cnt_reg <= '0;
		else
			cyc_cnt_reg <= cyc_cnt_reg + MSC_W'(1);
	end

	// delay timer state machine
	// idle lasts one cycle so each start counts from zero; count freezes once tripped
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_reg  <= NSOV_IDLE;
			ms_cnt_reg <= 16'h0;
		end else if (!int_start) begin
			state_reg  <= NSOV_IDLE;
			ms_cnt_reg <= 16'h0;
		end else begin
			unique case (state_reg)
				NSOV_IDLE: begin
					state_reg  <= NSOV_TIMING;
					ms_cnt_reg <= 16'h0;
				end
				NSOV_TIMING: begin
					if (delay_hit)
						state_reg <= NSOV_TRIPPED;
					else if (ms_tick)
						ms_cnt_reg <= ms_cnt_reg + 16'h1;
				end
				NSOV_TRIPPED: begin
					state_reg <= NSOV_TRIPPED;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// general outputs
	// ----------------------------------------------------------------
	// start and trip flops drive the pins directly
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			gst_reg <= 1'b0;
			gtr_reg <= 1'b0;
		end else begin
			gst_reg <= gst_next;
			gtr_reg <= gtr_next;
		end
	end

	// ----------------------------------------------------------------
	// interrupts
	// ----------------------------------------------------------------
	// sticky status; a rise in the same cycle as its clear wins,
	// so software never loses an event it has not yet read
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			irq_stat_reg <= 2'h0;
		else
			irq_stat_reg <= (irq_stat_reg & ~(wr_clr ? wd[1:0] : 2'h0))
			                | {rise_tr, rise_st};
	end

	// level interrupt, one cycle behind the status it reflects
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			irq_reg <= 1'b0;
		else
			irq_reg <= |(irq_stat_reg & irq_en_reg);
	end

	// ----------------------------------------------------------------
	// output drive
	// ----------------------------------------------------------------
	// every port comes straight from a flop, no logic after it
	assign avm_rsp_o.readdata    = rdata_reg;
	assign avm_rsp_o.waitrequest = wait_reg;
	assign general_start_out_o   = gst_reg;
	assign general_trip_out_o    = gtr_reg;
	assign irq_o                 = irq_reg;
endmodule // nsov_trip

// ==== test/nsov_props.sv ====
// Purpose: port checker of the trip block
// Assumes: bound onto nsov_trip
// Notes:   bus answers one cycle after a request
`timescale 1ns/100ps
module nsov_props #(
	parameter int VOLT_W = 8	// voltage width
) (
	input wire logic			clk_i,	// clock
	input wire logic			arst_n_i,	// reset, low
	input wire logic [VOLT_W-1:0]		negseq_volt_i,	// voltage
	input wire logic			volt_valid_i,	// strobe
	input wire logic			block_input_i,	// blocking
	input wire nsov_pkg::nsov_avm_req_t	avm_req_i,	// request
	input wire nsov_pkg::nsov_avm_rsp_t	avm_rsp_o,	// answer
	input wire logic			general_start_out_o,	// start
	input wire logic			general_trip_out_o	// trip
);
	wire busy = avm_req_i.read || avm_req_i.write;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	// decision outputs against their causes
	chk_trip_with_start: assert property (general_trip_out_o |-> general_start_out_o)
		else $error("trip without start");
	chk_block_quiet: assert property (block_input_i [*4] |->
		!general_start_out_o && !general_trip_out_o) else $error("output while blocked");
	chk_low_quiet: assert property ((volt_valid_i && negseq_volt_i <= 8'h02) [*4] |->
		!general_start_out_o) else $error("start at low voltage");
	chk_trip_not_early: assert property ($rose(general_start_out_o) |=>
		!general_trip_out_o [*8]) else $error("trip too early");
	chk_trip_drop: assert property ($fell(general_start_out_o) |-> !general_trip_out_o)
		else $error("trip outlived start");
	// register bus answer timing
	chk_wait_one: assert property (busy && avm_rsp_o.waitrequest |=> !avm_rsp_o.waitrequest)
		else $error("late bus answer");
	chk_wait_pulse: assert property (!avm_rsp_o.waitrequest |=> avm_rsp_o.waitrequest)
		else $error("long bus answer");
	chk_rdata_idle: assert property (avm_rsp_o.waitrequest |-> avm_rsp_o.readdata == 32'h0)
		else $error("read data outside answer");
endmodule // nsov_props

// ==== test/nsov_relay_model.sv ====
// Purpose: user blocking logic and relay trip logic
// Assumes: bench commands the blocking level
// Notes:   blocking is registered, as from a logic equation
`timescale 1ns/100ps
module nsov_relay_model (
	input wire logic	clk_i,		// clock
	input wire logic	arst_n_i,	// reset, low
	input wire logic	blk_cmd_i,	// bench asks blocking
	input wire logic	trip_i,		// general trip
	output logic		block_o,	// blocking level
	output int		trips_o		// trips executed
);
	logic trip_q;
	// blocking level and count of trip commands
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			block_o <= 1'b0;
			trip_q <= 1'b0;
			trips_o <= 0;
		end else begin
			block_o <= blk_cmd_i;
			trip_q <= trip_i;
			if (trip_i && !trip_q) trips_o <= trips_o + 1;
		end
	end
endmodule // nsov_relay_model

// ==== test/nsov_trip_test.sv ====
// Purpose: register and decision tests of the trip block
// Assumes: one ms is ten cycles here
// Notes:   outputs are read at the edge, before it updates them
`timescale 1ns/100ps
`include "nsov_defs.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
	$display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module nsov_trip_test;
	import nsov_pkg::*;
	logic		clk_i, arst_n_i, blk_cmd, blk, st, tr, irq;
	logic [7:0]	volt;
	logic [31:0]	q;
	nsov_avm_req_t	req;
	nsov_avm_rsp_t	rsp;
	int		fails, checked, trips, n;
	logic		vld;
	logic [3:0]	be;
	logic [7:0]	ta[5] = '{8'h04, 8'h04, 8'h08, 8'h08, 8'h04};
	logic [31:0]	tw[5] = '{32'h01, 32'h50, 32'hFFFF, 32'h10, 32'h14};
	logic [31:0]	te[5] = '{32'h02, 32'h28, 32'hEA60, 32'h32, 32'h14};
	nsov_trip #(.VOLT_W(8), .CYCLES_PER_MS(10)) dut (.clk_i(clk_i), .arst_n_i(arst_n_i),
		.negseq_volt_i(volt), .volt_valid_i(vld), .block_input_i(blk), .avm_req_i(req),
		.avm_rsp_o(rsp), .general_start_out_o(st), .general_trip_out_o(tr), .irq_o(irq));
	nsov_relay_model relay (.clk_i(clk_i), .arst_n_i(arst_n_i), .blk_cmd_i(blk_cmd),
		.trip_i(tr), .block_o(blk), .trips_o(trips));
	task automatic report_and_stop;
		$display("fails=%0d checked=%0d", fails, checked);
		if (fails == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// one bus access, held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk_i);
		req <= '{address: a, read: !wr, write: wr, writedata: d, byteenable: be};
		k = 0;
		do begin @(posedge clk_i); k++; end while (rsp.waitrequest !== 1'b0 && k < 20);
		q = rsp.readdata;
		req <= '0;
		if (k >= 20) begin fails++; report_and_stop; end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		`CHK("register", e, q)
	endtask
	// bounded wait for start or trip to reach a level
	task automatic wait_out(input bit trp, input logic v, input int lim);
		n = 0;
		while (((trp ? tr : st) !== v) && n < lim) begin @(posedge clk_i); n++; end
		if (n >= lim) begin fails++; report_and_stop; end
	endtask
	initial begin clk_i = 1'b0; forever #4 clk_i = ~clk_i; end
	initial begin
		arst_n_i = 1'b0; blk_cmd = 1'b0; volt = 8'h00; req = '0; fails = 0; checked = 0;
		vld = 1'b1; be = 4'hF;
		repeat (2) @(posedge clk_i);
		arst_n_i <= 1'b1;
		rd(`NSOV_OFF_CTRL, 32'h1);
		rd(`NSOV_OFF_VSET, 32'h1E);
		rd(`NSOV_OFF_DELAY, 32'h64);
		rd(`NSOV_OFF_IRQ_EN, 32'h0);
		rd(8'h20, 32'h0);
		for (int i = 0; i < 5; i++) begin
			bus(1'b1, ta[i], tw[i]);
			rd(ta[i], te[i]);
		end
		// upper byte alone keeps the lower byte of the delay
		be = 4'h2;
		bus(1'b1, `NSOV_OFF_DELAY, 32'h1234);
		be = 4'hF;
		rd(`NSOV_OFF_DELAY, 32'h1232);
		bus(1'b1, `NSOV_OFF_DELAY, 32'h32);
		bus(1'b1, `NSOV_OFF_IRQ_EN, 32'h3);
		// threshold is strict, then timed trip of 50 ms
		volt <= 8'h14;
		repeat (20) @(posedge clk_i);
		`CHK("start at threshold", 1'b0, st)
		vld <= 1'b0;
		volt <= 8'h15;
		repeat (20) @(posedge clk_i);
		`CHK("held sample", 1'b0, st)
		vld <= 1'b1;
		wait_out(0, 1'b1, 10);
		wait_out(1, 1'b1, 600);
		`CHK("trip delay", 1'b1, n >= 495 && n <= 510)
		repeat (2) @(posedge clk_i);
		`CHK("irq", 1'b1, irq)
		rd(`NSOV_OFF_IRQ_STAT, 32'h3);
		rd(`NSOV_OFF_STATUS, 32'hF);
		// drop below threshold clears start, trip and count
		volt <= 8'h00;
		wait_out(0, 1'b0, 5);
		`CHK("trip after drop", 1'b0, tr)
		rd(`NSOV_OFF_COUNT, 32'h0);
		bus(1'b1, `NSOV_OFF_IRQ_CLR, 32'h3);
		rd(`NSOV_OFF_IRQ_STAT, 32'h0);
		@(posedge clk_i);
		`CHK("irq cleared", 1'b0, irq)
		// start only: start but no trip
		bus(1'b1, `NSOV_OFF_CTRL, 32'h3);
		volt <= 8'h15;
		wait_out(0, 1'b1, 10);
		repeat (600) @(posedge clk_i);
		`CHK("trip start only", 1'b0, tr)
		rd(`NSOV_OFF_STATUS, 32'h7);
		rd(`NSOV_OFF_COUNT, 32'h32);
		// blocking holds both low, release restarts timing
		volt <= 8'h00;
		bus(1'b1, `NSOV_OFF_CTRL, 32'h1);
		blk_cmd <= 1'b1;
		repeat (6) @(posedge clk_i);
		volt <= 8'h15;
		repeat (600) @(posedge clk_i);
		`CHK("blocked", 2'b00, {st, tr})
		rd(`NSOV_OFF_STATUS, 32'h10);
		blk_cmd <= 1'b0;
		wait_out(0, 1'b1, 10);
		wait_out(1, 1'b1, 600);
		`CHK("trip after block", 1'b1, n >= 495 && n <= 510)
		// operation off
		bus(1'b1, `NSOV_OFF_CTRL, 32'h0);
		wait_out(0, 1'b0, 5);
		`CHK("trip off", 1'b0, tr)
		`CHK("trip count", 2, trips)
		report_and_stop;
	end
endmodule // nsov_trip_test
bind nsov_trip nsov_props #(.VOLT_W(VOLT_W)) u_props (.clk_i(clk_i), .arst_n_i(arst_n_i),
	.negseq_volt_i(negseq_volt_i), .volt_valid_i(volt_valid_i),
	.block_input_i(block_input_i), .avm_req_i(avm_req_i), .avm_rsp_o(avm_rsp_o),
	.general_start_out_o(general_start_out_o), .general_trip_out_o(general_trip_out_o));
